// file: rtl/fpds_pkg.sv
/*
  Constants, register map, field layout, reset values, timing counts and the
  spin-up state encoding shared by the fan drive block.
  Assumes a single 100 MHz clock and an 8-bit register port with documented offsets.
*/
package fpds_pkg;

  // clock and timing base
  localparam int CLK_HZ = 100_000_000;
  localparam int CLK_PERIOD_NS = 10;
  localparam int CLK_DHZ = CLK_HZ * 10; // clock in tenths of a hertz
  localparam int MS_NS = 1_000_000;
  localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS; // 1 ms tick for spin-up timing
  localparam int TACHO_INPUT_OSC_HZ = 90_000;
  localparam int TACHO_INPUT_TICK_CYCLES = CLK_HZ / TACHO_INPUT_OSC_HZ; // 90 kHz measurement tick
  localparam int PWM_STEPS = 256;
  localparam int CHANS = 3;
  localparam int FANS = 4;

  // drive frequencies in tenths of a hertz
  localparam int HF_DHZ = 225_000;
  localparam int LF_DHZ0 = 110;
  localparam int LF_DHZ1 = 147;
  localparam int LF_DHZ2 = 221;
  localparam int LF_DHZ3 = 294;
  localparam int LF_DHZ4 = 353;
  localparam int LF_DHZ5 = 441;
  localparam int LF_DHZ6 = 588;
  localparam int LF_DHZ7 = 882;

  // clock cycles per duty step for each frequency
  localparam logic [15:0] HF_STEP_CYCLES = 16'(CLK_DHZ / (HF_DHZ * PWM_STEPS));
  localparam logic [7:0][15:0] LF_STEP_DEFAULT = {
    16'(CLK_DHZ / (LF_DHZ7 * PWM_STEPS)),
    16'(CLK_DHZ / (LF_DHZ6 * PWM_STEPS)),
    16'(CLK_DHZ / (LF_DHZ5 * PWM_STEPS)),
    16'(CLK_DHZ / (LF_DHZ4 * PWM_STEPS)),
    16'(CLK_DHZ / (LF_DHZ3 * PWM_STEPS)),
    16'(CLK_DHZ / (LF_DHZ2 * PWM_STEPS)),
    16'(CLK_DHZ / (LF_DHZ1 * PWM_STEPS)),
    16'(CLK_DHZ / (LF_DHZ0 * PWM_STEPS))
  };

  // startup timeout per code, in ms (code 0 = none)
  localparam logic [7:0][11:0] SPIN_MS = {
    12'hfa0, 12'h7d0, 12'h3e8, 12'h29b, 12'h190, 12'h0fa, 12'h064, 12'h000
  };

  // register offsets
  localparam logic [7:0] OFS_DUTY1 = 8'h30;
  localparam logic [7:0] OFS_DUTY2 = 8'h31;
  localparam logic [7:0] OFS_DUTY3 = 8'h32;
  localparam logic [7:0] OFS_GLOBAL = 8'h40;
  localparam logic [7:0] OFS_SETUP1 = 8'h5c;
  localparam logic [7:0] OFS_SETUP2 = 8'h5d;
  localparam logic [7:0] OFS_SETUP3 = 8'h5e;
  localparam logic [7:0] OFS_FREQ1 = 8'h5f;
  localparam logic [7:0] OFS_FREQ2 = 8'h60;
  localparam logic [7:0] OFS_FREQ3 = 8'h61;
  localparam logic [7:0] OFS_PPR = 8'h7b;

  // field positions
  localparam int SETUP_SPIN_LSB = 0; // [2:0] startup timeout code
  localparam int SETUP_POL_BIT = 4; // output_polarity
  localparam int SETUP_BHV_LSB = 5; // [7:5] channel_behaviour
  localparam int DRIVE_SEL_A_SEL_LSB = 0; // [2:0] drive_sel_a
  localparam int DRIVE_SEL_A_HF_BIT = 3;
  localparam int GLOBAL_FIXED_BIT = 5; // fixed_spinup_select
  localparam logic [2:0] BHV_MANUAL = 3'h7;

  // reset values
  localparam logic [7:0] RST_DUTY = 8'h00;
  localparam logic [7:0] RST_SETUP = 8'he2; // manual, non-inverted, 250 ms
  localparam logic [7:0] RST_DRIVE_SEL_A = 8'h04; // low frequency, 35.3 Hz
  localparam logic [7:0] RST_PPR = 8'h55; // two pulses for every fan
  localparam logic [7:0] RST_GLOBAL = 8'h00;
  localparam logic [7:0] DUTY_FULL = 8'hff;
  localparam logic [1:0] SPIN_PULSES = 2'h2;

  typedef enum logic [2:0] {
    FPDS_SP_IDLE = 3'h1,
    FPDS_SP_SPIN = 3'h2,
    FPDS_SP_RUN = 3'h4
  } fpds_spin_t;

endpackage : fpds_pkg

// file: rtl/fpds_pwm_chan.sv
/*
  One PWM drive channel: 256-step duty with selectable step length and polarity.
  Assumes duty and controls come from logic on the same clock.
*/
`timescale 1ns/1ps
module fpds_pwm_chan #(
  parameter logic [15:0] HF_STEP = fpds_pkg::HF_STEP_CYCLES,
  parameter logic [7:0][15:0] LF_STEP = fpds_pkg::LF_STEP_DEFAULT
) (
  input wire logic mclk, // system clock
  input wire logic nrst, // async reset, active low
  input wire logic [7:0] duty, // applied duty
  input wire logic invert, // polarity select
  input wire logic fast, // high-frequency mode
  input wire logic [2:0] drive_sel_a_sel, // low-frequency code
  output logic pwm_out // drive pin
);

  typedef struct packed {
    logic [15:0] pre;
    logic [7:0] step;
    logic out;
  } fpds_pwm_t;

  fpds_pwm_t s_r;
  fpds_pwm_t s_nxt;
  logic [15:0] step_len;

  // fast mode overrides the low-frequency code
  assign step_len = fast ? HF_STEP : LF_STEP[drive_sel_a_sel]; // R8 R9

  // step prescaler, step counter and output level
  always_comb begin
    s_nxt = s_r;
    if (s_r.pre >= step_len - 16'h0001) begin
      s_nxt.pre = 16'h0000;
      s_nxt.step = s_r.step + 8'h01;
    end else begin
      s_nxt.pre = s_r.pre + 16'h0001;
    end
    // full scale held solid so 0xff is a true 100%
    s_nxt.out = ((duty == fpds_pkg::DUTY_FULL) || (s_r.step < duty)) ^ invert; // R12 R7
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign pwm_out = s_r.out;

endmodule : fpds_pwm_chan

// file: rtl/fpds_top.sv
/*
  Three-channel fan drive with spin-up, startup timeout, polarity, frequency
  select, manual or external automatic duty, and four tachometer period counters.
  Holds the host-visible setup, frequency, duty and pulse-count registers, one
  spin-up sequencer per channel and one period counter per tachometer line.
  Assumes a register port on mclk and tacho pins asynchronous to mclk.
  Assumes auto_duty comes from a temperature loop on the same clock, so it is
  used without synchronising; a write strobe held high writes every cycle.
  Assumes tacho_input lines idle high through their pull-ups while a fan stands still.
  Limitation: the millisecond base runs free, so a timeout may end up to one
  tick early; channel 3 counts the tacho_input edges of fans 3 and 4 together.
*/
// Summary of operation
// R1: two-bit pulses-per-revolution field for each fan
// R2: every fan defaults to two pulses
// R3: spin-up drives full duty until two pulses
// R4: timeout without two pulses raises interrupt
// R5: three-bit timeout code, reset 250 ms
// R6: fixed spin-up runs for timeout time
// R7: polarity bit inverts the drive output
// R8: high-frequency bit forces 22.5 kHz drive
// R9: three-bit code selects low drive frequency
// R10: behaviour code 111 means manual control
// R11: manual writes set the output duty
// R12: 8-bit duty maps linearly to output
// R13: duty reads return the applied duty
// R14: duty registers reset to zero
// R15: automatic mode follows temperature loop duty
// R16: 90 kHz ticks counted over N tacho_input periods
// R17: duty zero to nonzero starts spin-up
`timescale 1ns/1ps
module fpds_top #(
  parameter int MS_CYCLES = fpds_pkg::MS_CYCLES, // cycles per millisecond tick
  parameter logic [7:0][15:0] LF_STEP = fpds_pkg::LF_STEP_DEFAULT // low-frequency step lengths
) (
  input wire logic mclk, // system clock
  input wire logic nrst, // async reset, active low
  input wire logic [7:0] reg_addr, // register offset
  input wire logic [7:0] reg_wdata, // write data
  input wire logic reg_wr, // write strobe, one cycle
  output logic [7:0] reg_rdata, // read data, one cycle after address
  input wire logic [2:0][7:0] auto_duty, // duty from the temperature loop
  input wire logic [3:0] tacho_input, // fan tacho_input pins, async
  output logic [2:0] fan_drive, // PWM drive pins
  output logic [2:0] spin_fail, // startup timeout event, one cycle
  output logic [2:0] speed_irq_hold, // fan-speed interrupts held off
  output logic [3:0][15:0] tacho_input_period // latest period count per fan
);

  // prescaler widths, sized so the terminal count always fits
  localparam int MSW = $clog2(MS_CYCLES + 1);
  localparam int TKW = $clog2(fpds_pkg::TACHO_INPUT_TICK_CYCLES + 1);

  typedef struct packed {
    // host-visible registers
    logic [2:0][7:0] duty;
    logic [2:0][7:0] setup;
    logic [2:0][7:0] drive_sel_a;
    logic [7:0] ppr;
    logic [7:0] glob;
    // registered read data
    logic [7:0] rdata;
    // tacho_input synchroniser and edge memory
    logic [3:0] tsync1;
    logic [3:0] tsync2;
    logic [3:0] tprev;
    // spin-up sequencer per channel
    logic [2:0] cmd_nz;
    fpds_pkg::fpds_spin_t [2:0] spin;
    logic [2:0][1:0] pulses;
    logic [2:0][11:0] spin_ms;
    // shared time bases
    logic [MSW-1:0] ms_pre;
    logic [TKW-1:0] tk_pre;
    // period measurement per fan
    logic [3:0] armed;
    logic [3:0][2:0] periods;
    logic [3:0][15:0] meas;
    logic [3:0][15:0] result;
    // one-cycle timeout events
    logic [2:0] fail;
  } fpds_state_t;

  fpds_state_t s_r;
  fpds_state_t s_nxt;
  // per-channel duty path, filled by the generate loop
  logic [2:0][7:0] cmd_duty;
  logic [2:0][7:0] applied;
  logic [2:0] hold;

  // per-channel duty source, spin-up override and drive
  generate
    for (genvar c = 0; c < fpds_pkg::CHANS; c++) begin : g_chan
      logic manual;
      logic [11:0] lim;
      // any behaviour code other than manual follows the external loop
      assign manual = s_r.setup[c][fpds_pkg::SETUP_BHV_LSB +: 3] == fpds_pkg::BHV_MANUAL; // R10
      assign cmd_duty[c] = manual ? s_r.duty[c] : auto_duty[c]; // R11 R15
      // spin-up overrides whatever duty is commanded
      assign applied[c] = (s_r.spin[c] == fpds_pkg::FPDS_SP_SPIN) ? fpds_pkg::DUTY_FULL : cmd_duty[c]; // R3
      // timeout limit in milliseconds, zero when no timeout is set
      assign lim = fpds_pkg::SPIN_MS[s_r.setup[c][fpds_pkg::SETUP_SPIN_LSB +: 3]];
      // speed alarms stay quiet while a timeout is running
      assign hold[c] = (s_r.spin[c] == fpds_pkg::FPDS_SP_SPIN) && !s_r.glob[fpds_pkg::GLOBAL_FIXED_BIT]
        && (lim != 12'h000); // R4

      // one drive channel; polarity and frequency straight from the registers
      fpds_pwm_chan #(
        .HF_STEP(fpds_pkg::HF_STEP_CYCLES),
        .LF_STEP(LF_STEP)
      ) u_pwm (
        .mclk(mclk),
        .nrst(nrst),
        .duty(applied[c]),
        .invert(s_r.setup[c][fpds_pkg::SETUP_POL_BIT]),
        .fast(s_r.drive_sel_a[c][fpds_pkg::DRIVE_SEL_A_HF_BIT]),
        .drive_sel_a_sel(s_r.drive_sel_a[c][fpds_pkg::DRIVE_SEL_A_SEL_LSB +: 3]),
        .pwm_out(fan_drive[c])
      );
    end
  endgenerate

  // whole next state: registers, tacho_input sync, spin-up and period counters
  always_comb begin
    // scratch values, cleared first so nothing is latched
    logic ms_tick;
    logic tk_tick;
    logic [3:0] rises;
    logic rise_c;
    logic fixed;
    logic [11:0] lim_c;
    logic [1:0] pul;
    logic [2:0] nper;
    ms_tick = 1'b0;
    tk_tick = 1'b0;
    rises = 4'h0;
    rise_c = 1'b0;
    fixed = 1'b0;
    lim_c = 12'h000;
    pul = 2'h0;
    nper = 3'h0;
    s_nxt = s_r;

    // time bases
    // the millisecond tick times spin-up, the 90 kHz tick feeds the period counters
    ms_tick = s_r.ms_pre >= MSW'(MS_CYCLES - 1);
    s_nxt.ms_pre = ms_tick ? '0 : s_r.ms_pre + MSW'(1);
    tk_tick = s_r.tk_pre >= TKW'(fpds_pkg::TACHO_INPUT_TICK_CYCLES - 1);
    s_nxt.tk_pre = tk_tick ? '0 : s_r.tk_pre + TKW'(1);

    // two-stage sync, edges taken from the second stage only
    // a raw pin level could carry a metastable sample into the counters
    s_nxt.tsync1 = tacho_input;
    s_nxt.tsync2 = s_r.tsync1;
    s_nxt.tprev = s_r.tsync2;
    rises = s_r.tsync2 & ~s_r.tprev;

    // register writes
    if (reg_wr) begin
      case (reg_addr)
        // duty bytes are stored even in automatic mode, used once manual
        fpds_pkg::OFS_DUTY1: s_nxt.duty[0] = reg_wdata; // R11
        fpds_pkg::OFS_DUTY2: s_nxt.duty[1] = reg_wdata;
        fpds_pkg::OFS_DUTY3: s_nxt.duty[2] = reg_wdata;
        fpds_pkg::OFS_GLOBAL: s_nxt.glob = reg_wdata;
        fpds_pkg::OFS_SETUP1: s_nxt.setup[0] = reg_wdata;
        fpds_pkg::OFS_SETUP2: s_nxt.setup[1] = reg_wdata;
        fpds_pkg::OFS_SETUP3: s_nxt.setup[2] = reg_wdata;
        fpds_pkg::OFS_FREQ1: s_nxt.drive_sel_a[0] = reg_wdata;
        fpds_pkg::OFS_FREQ2: s_nxt.drive_sel_a[1] = reg_wdata;
        fpds_pkg::OFS_FREQ3: s_nxt.drive_sel_a[2] = reg_wdata;
        fpds_pkg::OFS_PPR: s_nxt.ppr = reg_wdata; // R1
        // unmapped offsets fall through and change nothing
        default: s_nxt.ppr = s_nxt.ppr;
      endcase
    end

    // read mux; duty offsets show what the pins really get
    // a read addressed in the cycle of a write still shows the old value
    case (reg_addr)
      fpds_pkg::OFS_DUTY1: s_nxt.rdata = applied[0]; // R13
      fpds_pkg::OFS_DUTY2: s_nxt.rdata = applied[1];
      fpds_pkg::OFS_DUTY3: s_nxt.rdata = applied[2];
      fpds_pkg::OFS_GLOBAL: s_nxt.rdata = s_r.glob;
      fpds_pkg::OFS_SETUP1: s_nxt.rdata = s_r.setup[0];
      fpds_pkg::OFS_SETUP2: s_nxt.rdata = s_r.setup[1];
      fpds_pkg::OFS_SETUP3: s_nxt.rdata = s_r.setup[2];
      fpds_pkg::OFS_FREQ1: s_nxt.rdata = s_r.drive_sel_a[0];
      fpds_pkg::OFS_FREQ2: s_nxt.rdata = s_r.drive_sel_a[1];
      fpds_pkg::OFS_FREQ3: s_nxt.rdata = s_r.drive_sel_a[2];
      fpds_pkg::OFS_PPR: s_nxt.rdata = s_r.ppr;
      // unmapped offsets read as zero
      default: s_nxt.rdata = 8'h00;
    endcase

    // spin-up sequencer per channel; channel 3 watches fans 3 and 4 both
    fixed = s_r.glob[fpds_pkg::GLOBAL_FIXED_BIT];
    for (int c = 0; c < fpds_pkg::CHANS; c++) begin
      rise_c = (c < 2) ? rises[c] : (rises[2] | rises[3]);
      lim_c = fpds_pkg::SPIN_MS[s_r.setup[c][fpds_pkg::SETUP_SPIN_LSB +: 3]]; // R5
      // command seen one cycle late, so a step from zero shows as an edge
      s_nxt.cmd_nz[c] = cmd_duty[c] != 8'h00;
      // timeout event lasts one cycle only
      s_nxt.fail[c] = 1'b0;
      // pulse count saturates at two, extra edges are harmless
      pul = s_r.pulses[c];
      if (rise_c && (pul != fpds_pkg::SPIN_PULSES)) begin
        pul = pul + 2'h1;
      end
      case (s_r.spin[c])
        // waiting for the commanded duty to leave zero
        fpds_pkg::FPDS_SP_IDLE: begin
          if ((cmd_duty[c] != 8'h00) && !s_r.cmd_nz[c]) begin
            s_nxt.spin[c] = fpds_pkg::FPDS_SP_SPIN; // R17
            s_nxt.pulses[c] = 2'h0;
            s_nxt.spin_ms[c] = 12'h000;
          end
        end
        // full drive; count tacho_input edges and milliseconds
        fpds_pkg::FPDS_SP_SPIN: begin
          s_nxt.pulses[c] = pul;
          if (ms_tick && (s_r.spin_ms[c] != 12'hfff)) begin
            s_nxt.spin_ms[c] = s_r.spin_ms[c] + 12'h001;
          end
          // dropping the command to zero abandons spin-up at once
          if (cmd_duty[c] == 8'h00) begin
            s_nxt.spin[c] = fpds_pkg::FPDS_SP_IDLE;
          end else if (fixed) begin
            // tacho_input ignored; code 000 ends spin-up after a single cycle
            if (s_r.spin_ms[c] >= lim_c) begin
              s_nxt.spin[c] = fpds_pkg::FPDS_SP_RUN; // R6
            end
          end else if (pul == fpds_pkg::SPIN_PULSES) begin
            s_nxt.spin[c] = fpds_pkg::FPDS_SP_RUN; // R3
          end else if ((lim_c != 12'h000) && (s_r.spin_ms[c] >= lim_c)) begin
            // give up, report, and fall back to the running duty
            s_nxt.fail[c] = 1'b1; // R4
            s_nxt.spin[c] = fpds_pkg::FPDS_SP_RUN;
          end
        end
        // running duty until the command drops to zero
        fpds_pkg::FPDS_SP_RUN: begin
          if (cmd_duty[c] == 8'h00) begin
            s_nxt.spin[c] = fpds_pkg::FPDS_SP_IDLE;
          end
        end
        default: s_nxt.spin[c] = fpds_pkg::FPDS_SP_IDLE;
      endcase
    end

    // period counters: first edge arms, N edges later the count is latched
    for (int f = 0; f < fpds_pkg::FANS; f++) begin
      // compare against code plus one: code 00 counts one period
      nper = s_r.periods[f] + 3'h1;
      if (rises[f]) begin
        if (!s_r.armed[f]) begin
          s_nxt.armed[f] = 1'b1;
          s_nxt.meas[f] = 16'h0000;
          s_nxt.periods[f] = 3'h0;
        end else if (nper == ({1'b0, s_r.ppr[2 * f +: 2]} + 3'h1)) begin
          s_nxt.result[f] = s_r.meas[f]; // R16 R1
          s_nxt.meas[f] = 16'h0000;
          s_nxt.periods[f] = 3'h0;
        end else begin
          s_nxt.periods[f] = nper;
        end
      end else if (tk_tick && s_r.armed[f] && (s_r.meas[f] != 16'hffff)) begin
        // saturates, so a period too long to count latches full scale; a stalled fan keeps its last result
        s_nxt.meas[f] = s_r.meas[f] + 16'h0001; // R16
      end
    end
  end

  // state register with documented power-on values
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      // everything not listed below powers up at zero
      s_r <= '0;
      s_r.duty <= {3{fpds_pkg::RST_DUTY}}; // R14
      s_r.setup <= {3{fpds_pkg::RST_SETUP}}; // R5
      s_r.drive_sel_a <= {3{fpds_pkg::RST_DRIVE_SEL_A}}; // R9
      s_r.ppr <= fpds_pkg::RST_PPR; // R2
      s_r.glob <= fpds_pkg::RST_GLOBAL;
      s_r.spin[0] <= fpds_pkg::FPDS_SP_IDLE;
      s_r.spin[1] <= fpds_pkg::FPDS_SP_IDLE;
      s_r.spin[2] <= fpds_pkg::FPDS_SP_IDLE;
      // tacho_input lines idle high, so the edge memory starts high: no false edge after reset
      s_r.tsync1 <= 4'hf;
      s_r.tsync2 <= 4'hf;
      s_r.tprev <= 4'hf;
    end else begin
      s_r <= s_nxt;
    end
  end

  // outputs straight from the state, except the decoded hold-off
  assign reg_rdata = s_r.rdata;
  assign spin_fail = s_r.fail;
  assign speed_irq_hold = hold;
  assign tacho_input_period = s_r.result;

endmodule : fpds_top

// file: test/fpds_fan_model.sv
/*
  fan set model: tacho_input lines of four fans.
  assumes open-drain tacho_input lines with pull-up, so a stopped fan reads high.
*/
`timescale 1ns/1ps
module fpds_fan_model #(
  parameter int HALF = 1111 // cycles per tacho_input half period
) (
  input wire logic mclk, // time base
  input wire logic [3:0] alive, // fan spinning
  output logic [3:0] tacho // tacho_input lines
);
  int cnt = 0;
  logic ph = 1'b1;
  // shared tacho_input phase; a stalled fan leaves its line to the pull-up
  always @(posedge mclk) begin
    cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
    if (cnt == HALF - 1) begin
      ph <= ~ph;
    end
  end
  assign tacho = ~alive | {4{ph}};
endmodule : fpds_fan_model

// file: test/fpds_chk.sv
/*
  checker for the fan drive top: port relations over time.
  assumes binding onto fpds_top with MS_CYCLES handed on.
*/
`timescale 1ns/1ps
module fpds_chk #(
  parameter int MS_CYCLES = 100 // cycles per ms tick
) (
  input wire logic mclk, // clock
  input wire logic nrst, // reset, active low
  input wire logic [7:0] reg_addr, // offset
  input wire logic [7:0] reg_wdata, // write data
  input wire logic reg_wr, // write strobe
  input wire logic [7:0] reg_rdata, // read data
  input wire logic [2:0] fan_drive, // drive pins
  input wire logic [2:0] spin_fail, // timeout events
  input wire logic [2:0] speed_irq_hold // irq hold-off
);
  // shortest timeout less one early ms tick and a little slack
  localparam int unsigned MIN_WAIT = 99 * MS_CYCLES - 4;
  int unsigned hold_cnt_r;
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  // length of the running spin-up of channel 1
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      hold_cnt_r <= 0;
    end else begin
      hold_cnt_r <= speed_irq_hold[0] ? hold_cnt_r + 1 : 0;
    end
  end
  a_ppr_rw: assert property (reg_wr && reg_addr == 8'h7b ##1 reg_addr == 8'h7b
    |=> reg_rdata == $past(reg_wdata, 2)) else $error("ppr readback wrong");
  a_setup_rw: assert property (reg_wr && reg_addr == 8'h5c ##1 reg_addr == 8'h5c
    |=> (reg_rdata & 8'hf7) == ($past(reg_wdata, 2) & 8'hf7)) else $error("setup readback wrong");
  a_fail_pulse: assert property ((spin_fail & $past(spin_fail)) == 3'h0)
    else $error("timeout event longer than one cycle");
  a_fail_in_spin: assert property ((spin_fail & ~$past(speed_irq_hold)) == 3'h0)
    else $error("timeout event outside spin-up");
  a_fail_ends_spin: assert property (spin_fail[0] |-> ##[0:2] !speed_irq_hold[0])
    else $error("spin-up kept after timeout");
  a_fail_min_wait: assert property (spin_fail[0] |-> hold_cnt_r >= MIN_WAIT)
    else $error("timeout came too early");
  a_spin_reads_full: assert property (speed_irq_hold[0] && $past(speed_irq_hold[0])
    && reg_addr == 8'h30 |=> reg_rdata == 8'hff) else $error("spin-up duty not full");
  a_spin_drive_solid: assert property (speed_irq_hold[0] && $past(speed_irq_hold[0], 3)
    |-> $stable(fan_drive[0])) else $error("drive toggles in spin-up");
  c_fail: cover property (spin_fail[0]);
  c_spin_done: cover property ($fell(speed_irq_hold[1]));
  c_fixed_wr: cover property (reg_wr && reg_addr == 8'h40);
endmodule : fpds_chk
bind fpds_top fpds_chk #(.MS_CYCLES(MS_CYCLES)) u_chk (.mclk(mclk), .nrst(nrst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rdata(reg_rdata),
  .fan_drive(fan_drive), .spin_fail(spin_fail), .speed_irq_hold(speed_irq_hold));

// file: test/test_fan_pwm_drive_and_spinup.sv
/*
  testbench for the fan drive top: register tasks, spin-up, timing, drive shape.
  assumes ms tick shortened to 100 cycles and low-frequency steps of 2..9 cycles.
*/
`timescale 1ns/1ps
module test_fan_pwm_drive_and_spinup;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic [2:0][7:0] auto_duty = '0;
  logic [3:0] alive = 4'h0;
  logic [7:0] reg_rdata;
  logic [3:0] tacho_input;
  logic [2:0] fan_drive;
  logic [2:0] spin_fail;
  logic [2:0] speed_irq_hold;
  logic [3:0][15:0] tacho_input_period;
  logic [7:0] rst_a [11] = '{8'h30, 8'h31, 8'h32, 8'h5c, 8'h5d, 8'h5e, 8'h5f, 8'h60, 8'h61, 8'h7b, 8'h40};
  logic [7:0] rst_e [11] = '{8'h00, 8'h00, 8'h00, 8'he2, 8'he2, 8'he2, 8'h04, 8'h04, 8'h04, 8'h55, 8'h00};
  int error_cnt = 0;
  int samples_checked = 0;
  int cyc = 0;
  int n;
  always #5 mclk = ~mclk;
  fpds_top #(.MS_CYCLES(100), .LF_STEP({16'd9, 16'd8, 16'd7, 16'd6, 16'd5, 16'd4, 16'd3, 16'd2})) i_dut (
    .mclk(mclk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rdata(reg_rdata), .auto_duty(auto_duty), .tacho_input(tacho_input), .fan_drive(fan_drive),
    .spin_fail(spin_fail), .speed_irq_hold(speed_irq_hold), .tacho_input_period(tacho_input_period));
  fpds_fan_model #(.HALF(1111)) i_fans (.mclk(mclk), .alive(alive), .tacho(tacho_input));
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic chk_rng(input logic [31:0] g, input int lo, input int hi);
    samples_checked++;
    if ((g >= lo && g <= hi) !== 1'b1) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got %0d not in %0d..%0d", $time, g, lo, hi);
    end
  endtask : chk_rng
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr
  // read lands one cycle after the address is taken
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk);
    reg_addr <= a;
    @(posedge mclk);
    #1;
    chk(reg_rdata, e);
  endtask : rdc
  // bounded wait for a channel to leave spin-up
  task automatic wait_low(input int ch, input int lim);
    n = 0;
    while (speed_irq_hold[ch] !== 1'b0 && n < lim) begin
      @(posedge mclk);
      #1;
      n++;
    end
  endtask : wait_low
  // high cycles of channel 2 over one window, after a short settle
  task automatic meas(input int len, output int hi);
    repeat (20) @(posedge mclk);
    hi = 0;
    repeat (len) begin
      @(posedge mclk);
      #1;
      hi += fan_drive[1];
    end
  endtask : meas
  task automatic done_t(input string s);
    $display("test %s done", s);
  endtask : done_t
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : tally_and_finish
  // hang guard, well above the expected run length
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 100000) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t timeout", $time);
      tally_and_finish();
    end
  end
  // main sequence
  initial begin
    repeat (4) @(posedge mclk);
    nrst <= 1'b1;
    for (int i = 0; i < 11; i++) begin
      rdc(rst_a[i], rst_e[i]);
    end
    done_t("reset");
    wr(8'h7b, 8'he4);
    rdc(8'h7b, 8'he4);
    alive <= 4'hf;
    n = 0;
    while (tacho_input_period[3] === 16'h0000 && n < 20000) begin
      @(posedge mclk);
      n++;
    end
    for (int i = 0; i < 4; i++) begin
      chk_rng(tacho_input_period[i], 2 * i + 1, 2 * i + 3);
    end
    done_t("tacho_input");
    wr(8'h5c, 8'he1);
    wr(8'h30, 8'h80);
    rdc(8'h30, 8'hff);
    chk(speed_irq_hold[0], 1'b1);
    wait_low(0, 6000);
    rdc(8'h30, 8'h80);
    done_t("spinup");
    alive <= 4'he;
    wr(8'h30, 8'h00);
    wr(8'h30, 8'h40);
    repeat (2) @(posedge mclk);
    wait_low(0, 12000);
    chk_rng(n, 9880, 10020);
    rdc(8'h30, 8'h40);
    done_t("timeout");
    alive <= 4'hf;
    wr(8'h40, 8'h20);
    wr(8'h30, 8'h00);
    wr(8'h30, 8'h40);
    repeat (4000) @(posedge mclk);
    rdc(8'h30, 8'hff);
    chk(speed_irq_hold[0], 1'b0);
    repeat (6500) @(posedge mclk);
    rdc(8'h30, 8'h40);
    wr(8'h40, 8'h00);
    done_t("fixed");
    wr(8'h31, 8'h40);
    repeat (3) @(posedge mclk);
    wait_low(1, 6000);
    for (int k = 0; k < 8; k++) begin
      wr(8'h60, 8'(k));
      meas(256 * (k + 2), n);
      chk(16'(n), 16'(64 * (k + 2)));
    end
    wr(8'h60, 8'h08);
    meas(4352, n);
    chk(16'(n), 16'd1088);
    wr(8'h5d, 8'hf2);
    meas(4352, n);
    chk(16'(n), 16'd3264);
    done_t("drive");
    wr(8'h5e, 8'h02);
    auto_duty[2] <= 8'h20;
    rdc(8'h32, 8'hff);
    wait_low(2, 6000);
    rdc(8'h32, 8'h20);
    done_t("auto");
    tally_and_finish();
  end
endmodule : test_fan_pwm_drive_and_spinup
